// [common/clk_ctrl_pkg.sv]
// Package of constants and types for the system clock control block
`default_nettype none
package clk_ctrl_pkg;
	// ***************************************************************
	// Clock rate and timing
	// ***************************************************************
	localparam int CLK_HZ = 25000000;
	localparam int CLK_NS = 40;
	localparam int WAKE_CYCLES = 6;
	localparam int RESET_BASE_CYCLES = 14;
	localparam int DELAY_SHORT_US = 4100;
	localparam int DELAY_LONG_US = 65000;
	// Round down is not wanted here: a least delay rounds up
	localparam int DELAY_SHORT_CYCLES = (DELAY_SHORT_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int DELAY_LONG_CYCLES = (DELAY_LONG_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int UNLOCK_CYCLES = 4;

	// ***************************************************************
	// Register map (byte addresses, word aligned)
	// ***************************************************************
	localparam logic [3:0] ADDR_TRIM = 4'h0;
	localparam logic [3:0] ADDR_DIVIDER = 4'h4;
	localparam logic [3:0] ADDR_ASYNC = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;

	// ***************************************************************
	// Field layouts and reset values
	// ***************************************************************
	localparam int CHANGE_ENABLE_BIT = 7;
	localparam int EXT_TIMER_CLK_BIT = 6;
	localparam logic [3:0] DIV_RESET_FUSE = 4'h3;
	localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
	localparam logic [3:0] DIV_MAX_CODE = 4'h8;
	localparam logic [3:0] SRC_EXTERNAL = 4'h0;
	localparam logic [3:0] SRC_RC_OSC = 4'h2;
	localparam logic [1:0] SUT_SHORT = 2'h0;
	localparam logic [1:0] SUT_MID = 2'h1;
	localparam logic [1:0] SUT_LONG = 2'h2;

	// ***************************************************************
	// Start-up sequencer states
	// ***************************************************************
	typedef enum logic [3:0] {
		ST_HOLD = 4'h1,
		ST_DELAY = 4'h2,
		ST_RUN = 4'h4,
		ST_WAKE = 4'h8
	} startup_state_t;
endpackage
`default_nettype wire

// [common/div_if.sv]
// Interface carrying the divider request from the register file to the divider
`timescale 1ns/100ps
`default_nettype none
interface div_if;
	logic [3:0] select;
	logic run;
	logic tick;
	modport ctrl (output select, output run, input tick);
	modport div (input select, input run, output tick);
endinterface
`default_nettype wire

// [rtl/clk_divider.sv]
// Glitch-free power-of-two system clock divider
`timescale 1ns/100ps
`default_nettype none
module clk_divider (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	// Control
	div_if.div ctl
);
	logic [7:0] count;
	logic [3:0] active;
	logic [8:0] limit;
	logic wrap;

	// Terminal count of the currently active factor
	assign limit = 9'h001 << active;
	assign wrap = ({1'b0, count} + 9'h001) >= limit;

	// New factor only adopted at a period boundary, so no short period arises
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			count <= 8'h00;
			active <= 4'h0;
		end else if (!ctl.run) begin
			count <= 8'h00;
		end else if (wrap) begin
			count <= 8'h00;
			active <= ctl.select; // [R10] [R11]
		end else begin
			count <= count + 8'h01;
		end
	end

	// One enable pulse per divided period
	assign ctl.tick = ctl.run && wrap;
endmodule
`default_nettype wire

// [rtl/startup_timer.sv]
// Reset and wake start-up delay counter
`timescale 1ns/100ps
`default_nettype none
module startup_timer (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	// Load and status
	input wire logic load_in,
	input wire logic [23:0] cycles_in,
	output logic done_out
);
	logic [23:0] remain;

	// Counts down a loaded delay; done while zero
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			remain <= 24'h000000;
		end else if (load_in) begin
			remain <= cycles_in;
		end else if (remain != 24'h000000) begin
			remain <= remain - 24'h000001;
		end
	end

	assign done_out = (remain == 24'h000000) && !load_in;
endmodule
`default_nettype wire

// [rtl/system_clock_control.sv]
// System clock control: source select, start-up delay, prescaler, trim, clock out
// Behaviour
// R01: External clock input drives the system when source fuse code is 0000.
// R02: Wake from power-down or power-save waits six cycles.
// R03: Reset delay is 14 cycles, plus 4.1 ms or 65 ms per start-up fuse.
// R04: External source changes under 2 percent per cycle, else in reset.
// R05: Clock output fuse drives system clock on its pin, also in reset.
// R06: Clock output pin carries the divided system clock.
// R07: Timer oscillator only with RC oscillator selected, system clock four times faster.
// R08: Timer external clock select bit takes external clock on timer pin.
// R09: Prescaler divides CPU, I/O, ADC and flash clocks together.
// R10: Divider change makes no glitch nor any faster intermediate period.
// R11: New factor active within old plus one to two new periods.
// R12: Change needs enable write then divider write within four cycles.
// R13: Change-enable updates only when other bits are written zero.
// R14: Change-enable clears after four cycles or on divider write, no extension.
// R15: Codes 0 to 8 divide by two to the code; others reserved.
// R16: Divider resets to 0011 with divide-by-eight fuse, else 0000.
// R17: Trim register loads factory value at reset; writes retune oscillator.
// R18: Top trim bit picks low or high range.
// R19: Lower seven trim bits tune upward within the range.
// R20: Software keeps trim at or below 8.8 MHz during memory writes.
// R21: Software disables interrupts during the divider change sequence.
// R22: Divider register reads enable and divider bits, bits 6 to 4 zero.
`timescale 1ns/100ps
`default_nettype none
module system_clock_control #(
	parameter int DELAY_SHORT = clk_ctrl_pkg::DELAY_SHORT_CYCLES,
	parameter int DELAY_LONG = clk_ctrl_pkg::DELAY_LONG_CYCLES,
	parameter logic [7:0] FACTORY_TRIM = 8'h80 // Arbitrary neutral value
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RESET_IN,
	// Avalon-MM slave
	input wire logic [3:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// Fuses
	input wire logic [3:0] CLOCK_SOURCE_SELECT_FUSE_IN,
	input wire logic [1:0] STARTUP_DELAY_FUSE_IN,
	input wire logic CLOCK_OUTPUT_FUSE_IN,
	input wire logic DIVIDE_BY_EIGHT_FUSE_IN,
	// Sleep wake request from power management
	input wire logic DEEP_WAKE_IN,
	// Pins
	input wire logic CRYSTAL_INPUT_PIN_IN,
	input wire logic TIMER_OSC_INPUT_PIN_IN,
	input wire logic PORT_PIN_DATA_IN,
	output logic CLOCK_OUTPUT_PIN_OUT,
	// Clock enables to the domains
	output logic CPU_CLK_EN_OUT,
	output logic IO_CLK_EN_OUT,
	output logic ADC_CLK_EN_OUT,
	output logic FLASH_CLK_EN_OUT,
	// Oscillator and timer controls
	output logic [7:0] RC_OSCILLATOR_TRIM_OUT,
	output logic TRIM_RANGE_SELECT_OUT,
	output logic EXTERNAL_SOURCE_ACTIVE_OUT,
	output logic TIMER_OSC_ALLOWED_OUT,
	output logic TIMER_CLOCK_OUT,
	output logic TIMER_CLOCK_VALID_OUT,
	output logic [3:0] DIVIDER_SELECT_OUT
);
	// ***************************************************************
	// Registers and wires
	// ***************************************************************
	clk_ctrl_pkg::startup_state_t state, next_state;
	logic [7:0] rc_oscillator_trim;
	logic [3:0] divider_select;
	logic divider_change_enable;
	logic [2:0] unlock_count;
	logic timer_external_clock_select;
	logic rd_ack;
	logic fuse_div8;
	logic timer_load;
	logic timer_done;
	logic [23:0] timer_cycles;
	logic [23:0] reset_cycles;
	logic sys_tick;
	logic src_src;
	div_if dv ();

	// Address decode on byte addresses with lane 0 strobe
	wire wr_lane0 = AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
	wire wr_trim = wr_lane0 && (AVS_ADDRESS_IN == clk_ctrl_pkg::ADDR_TRIM);
	wire wr_div = wr_lane0 && (AVS_ADDRESS_IN == clk_ctrl_pkg::ADDR_DIVIDER);
	wire wr_async = wr_lane0 && (AVS_ADDRESS_IN == clk_ctrl_pkg::ADDR_ASYNC);
	wire [7:0] wbyte = AVS_WRITEDATA_IN[7:0];
	wire others_zero = (wbyte[6:0] == 7'h00);
	wire enable_write = wr_div && wbyte[clk_ctrl_pkg::CHANGE_ENABLE_BIT] && others_zero; // [R13]
	wire select_write = wr_div && !wbyte[clk_ctrl_pkg::CHANGE_ENABLE_BIT] && divider_change_enable; // [R12]
	wire plain_write = wr_div && !wbyte[clk_ctrl_pkg::CHANGE_ENABLE_BIT];
	wire unlock_expired = (unlock_count == 3'(clk_ctrl_pkg::UNLOCK_CYCLES - 1));
	wire is_external = (CLOCK_SOURCE_SELECT_FUSE_IN == clk_ctrl_pkg::SRC_EXTERNAL); // [R01]
	wire is_rc = (CLOCK_SOURCE_SELECT_FUSE_IN == clk_ctrl_pkg::SRC_RC_OSC);

	// Reserved codes clamp to the largest factor
	function automatic logic [3:0] legal_code(input logic [3:0] code);
		legal_code = (code > clk_ctrl_pkg::DIV_MAX_CODE) ? clk_ctrl_pkg::DIV_MAX_CODE : code; // [R15]
	endfunction

	// ***************************************************************
	// Start-up delay selection
	// ***************************************************************
	// Reserved start-up code takes the longest delay as the safe side
	always_comb begin
		unique case (STARTUP_DELAY_FUSE_IN)
			clk_ctrl_pkg::SUT_SHORT: reset_cycles = 24'(clk_ctrl_pkg::RESET_BASE_CYCLES); // [R03]
			clk_ctrl_pkg::SUT_MID: reset_cycles = 24'(clk_ctrl_pkg::RESET_BASE_CYCLES + DELAY_SHORT); // [R03]
			clk_ctrl_pkg::SUT_LONG: reset_cycles = 24'(clk_ctrl_pkg::RESET_BASE_CYCLES + DELAY_LONG); // [R03]
			default: reset_cycles = 24'(clk_ctrl_pkg::RESET_BASE_CYCLES + DELAY_LONG);
		endcase
	end

	// Loaded once leaving reset, or on a deep-sleep wake
	assign timer_load = (state == clk_ctrl_pkg::ST_HOLD) || (state == clk_ctrl_pkg::ST_RUN && DEEP_WAKE_IN);
	assign timer_cycles = (state == clk_ctrl_pkg::ST_HOLD) ? reset_cycles :
		24'(clk_ctrl_pkg::WAKE_CYCLES - 1); // [R02]

	startup_timer u_timer (
		.CLK_IN(CLK_IN),
		.RESET_IN(RESET_IN),
		.load_in(timer_load),
		.cycles_in(timer_cycles),
		.done_out(timer_done)
	);

	// ***************************************************************
	// Start-up sequencer
	// ***************************************************************
	always_comb begin
		next_state = state;
		unique case (state)
			clk_ctrl_pkg::ST_HOLD: next_state = clk_ctrl_pkg::ST_DELAY;
			clk_ctrl_pkg::ST_DELAY: if (timer_done) next_state = clk_ctrl_pkg::ST_RUN;
			clk_ctrl_pkg::ST_RUN: if (DEEP_WAKE_IN) next_state = clk_ctrl_pkg::ST_WAKE;
			clk_ctrl_pkg::ST_WAKE: if (timer_done) next_state = clk_ctrl_pkg::ST_RUN;
			default: next_state = clk_ctrl_pkg::ST_HOLD;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			state <= clk_ctrl_pkg::ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// Fuse strap caught in the first cycle after reset release
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			fuse_div8 <= 1'b0;
		end else if (state == clk_ctrl_pkg::ST_HOLD) begin
			fuse_div8 <= DIVIDE_BY_EIGHT_FUSE_IN;
		end
	end

	// ***************************************************************
	// Prescale register with timed unlock
	// ***************************************************************
	// Count starts only on the first enable write; rewrite does not restart it
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			divider_change_enable <= 1'b0;
			unlock_count <= 3'h0;
		end else if (divider_change_enable) begin
			if (unlock_expired || plain_write) begin
				divider_change_enable <= 1'b0; // [R14]
			end
			unlock_count <= unlock_count + 3'h1;
		end else if (enable_write) begin
			divider_change_enable <= 1'b1; // [R12]
			unlock_count <= 3'h0;
		end
	end

	// Divider bits: reset value from the fuse, then only unlocked writes
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			divider_select <= clk_ctrl_pkg::DIV_RESET_PLAIN;
		end else if (state == clk_ctrl_pkg::ST_HOLD) begin
			divider_select <= DIVIDE_BY_EIGHT_FUSE_IN ? clk_ctrl_pkg::DIV_RESET_FUSE :
				clk_ctrl_pkg::DIV_RESET_PLAIN; // [R16]
		end else if (select_write) begin
			divider_select <= wbyte[3:0]; // [R12]
		end
	end

	// ***************************************************************
	// Trim and timer clock select registers
	// ***************************************************************
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			rc_oscillator_trim <= FACTORY_TRIM; // [R17]
			timer_external_clock_select <= 1'b0;
		end else begin
			if (wr_trim) begin
				rc_oscillator_trim <= wbyte; // [R17]
			end
			if (wr_async) begin
				timer_external_clock_select <= wbyte[clk_ctrl_pkg::EXT_TIMER_CLK_BIT]; // [R08]
			end
		end
	end

	// ***************************************************************
	// Bus answer
	// ***************************************************************
	// Reads wait one cycle so read data come from a flip-flop
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			rd_ack <= 1'b0;
			AVS_READDATA_OUT <= 32'h00000000;
		end else begin
			rd_ack <= AVS_READ_IN && !rd_ack;
			unique case (AVS_ADDRESS_IN)
				clk_ctrl_pkg::ADDR_TRIM: AVS_READDATA_OUT <= {24'h000000, rc_oscillator_trim};
				clk_ctrl_pkg::ADDR_DIVIDER: AVS_READDATA_OUT <= {24'h000000, divider_change_enable,
					3'h0, divider_select}; // [R22]
				clk_ctrl_pkg::ADDR_ASYNC: AVS_READDATA_OUT <= {25'h0000000, timer_external_clock_select,
					6'h00};
				clk_ctrl_pkg::ADDR_STATUS: AVS_READDATA_OUT <= {28'h0000000, state};
				default: AVS_READDATA_OUT <= 32'h00000000;
			endcase
		end
	end

	assign AVS_WAITREQUEST_OUT = AVS_READ_IN && !rd_ack;

	// ***************************************************************
	// Divider and clock distribution
	// ***************************************************************
	assign dv.select = legal_code(divider_select); // [R15]
	assign dv.run = (state == clk_ctrl_pkg::ST_RUN);

	clk_divider u_div (
		.CLK_IN(CLK_IN),
		.RESET_IN(RESET_IN),
		.ctl(dv)
	);

	// One enable for all four domains keeps them in step
	assign sys_tick = dv.tick;
	assign CPU_CLK_EN_OUT = sys_tick; // [R09]
	assign IO_CLK_EN_OUT = sys_tick; // [R09]
	assign ADC_CLK_EN_OUT = sys_tick; // [R09]
	assign FLASH_CLK_EN_OUT = sys_tick; // [R09] [R10] [R11]

	// Source clock: external input or, for other sources, a constant high level
	assign src_src = is_external ? CRYSTAL_INPUT_PIN_IN : 1'b1; // [R01]

	// Divided clock shown on the pin; in reset the undivided clock keeps running.
	// The first reset cycle seeds a known level, as a toggle cannot start from nothing
	always_ff @(posedge CLK_IN) begin
		if (!RESET_IN || state == clk_ctrl_pkg::ST_HOLD) begin
			if (!CLOCK_OUTPUT_FUSE_IN) begin
				CLOCK_OUTPUT_PIN_OUT <= PORT_PIN_DATA_IN;
			end else if (state != clk_ctrl_pkg::ST_RUN) begin
				CLOCK_OUTPUT_PIN_OUT <= ~CLOCK_OUTPUT_PIN_OUT; // [R05]
			end else if (sys_tick) begin
				CLOCK_OUTPUT_PIN_OUT <= ~CLOCK_OUTPUT_PIN_OUT; // [R06]
			end
		end else begin
			CLOCK_OUTPUT_PIN_OUT <= 1'b0; // [R05]
		end
	end

	// ***************************************************************
	// Oscillator and timer pin outputs
	// ***************************************************************
	assign RC_OSCILLATOR_TRIM_OUT = rc_oscillator_trim; // [R19]
	assign TRIM_RANGE_SELECT_OUT = rc_oscillator_trim[7]; // [R18]
	assign EXTERNAL_SOURCE_ACTIVE_OUT = is_external && src_src; // [R01]
	assign TIMER_OSC_ALLOWED_OUT = is_rc; // [R07]
	assign TIMER_CLOCK_OUT = timer_external_clock_select && is_rc && TIMER_OSC_INPUT_PIN_IN; // [R08]
	assign TIMER_CLOCK_VALID_OUT = timer_external_clock_select && is_rc; // [R08]
	assign DIVIDER_SELECT_OUT = divider_select;

	// ***************************************************************
	// Assertions
	// ***************************************************************
	sequence s_enable_write;
		!divider_change_enable && enable_write;
	endsequence
	property p_unlock_window;
		@(posedge CLK_IN) disable iff (RESET_IN)
		s_enable_write ##1 (!plain_write) [*4] |=> !divider_change_enable;
	endproperty
	a_unlock_window: assert property (p_unlock_window) else $error("enable bit outlived window"); // [R14]
	property p_enable_needs_zero;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(wr_div && !others_zero && !divider_change_enable) |=> !divider_change_enable;
	endproperty
	a_enable_needs_zero: assert property (p_enable_needs_zero) else $error("enable set by dirty write"); // [R13]
	property p_locked_divider;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state != clk_ctrl_pkg::ST_HOLD && !select_write) |=> $stable(divider_select);
	endproperty
	a_locked_divider: assert property (p_locked_divider) else $error("divider changed while locked"); // [R12]
	property p_div_reset;
		@(posedge CLK_IN) (state == clk_ctrl_pkg::ST_HOLD && !RESET_IN) |=>
		(divider_select == (fuse_div8 ? clk_ctrl_pkg::DIV_RESET_FUSE : clk_ctrl_pkg::DIV_RESET_PLAIN));
	endproperty
	a_div_reset: assert property (p_div_reset) else $error("wrong divider reset value"); // [R16]
	property p_read_zero;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(rd_ack && AVS_ADDRESS_IN == clk_ctrl_pkg::ADDR_DIVIDER) |-> AVS_READDATA_OUT[6:4] == 3'h0;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("reserved divider bits nonzero"); // [R22]
	property p_wake_six;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(state == clk_ctrl_pkg::ST_RUN && DEEP_WAKE_IN) |=>
		(state == clk_ctrl_pkg::ST_WAKE) [*6] ##1 (state == clk_ctrl_pkg::ST_RUN);
	endproperty
	a_wake_six: assert property (p_wake_six) else $error("wake delay not six cycles"); // [R02]
	property p_tick_unity;
		@(posedge CLK_IN) disable iff (RESET_IN)
		(dv.run && $past(dv.run) && divider_select == 4'h0 && $past(divider_select) == 4'h0
		&& $past(sys_tick)) |-> sys_tick;
	endproperty
	a_tick_unity: assert property (p_tick_unity) else $error("undivided clock missed tick"); // [R09]
	property p_trim_write;
		@(posedge CLK_IN) disable iff (RESET_IN)
		wr_trim |=> RC_OSCILLATOR_TRIM_OUT == $past(wbyte) && TRIM_RANGE_SELECT_OUT == $past(wbyte[7]);
	endproperty
	a_trim_write: assert property (p_trim_write) else $error("trim write lost"); // [R17]
endmodule
`default_nettype wire

// [testbench/clock_source_model.sv]
// Far-side model: external clock source and timer oscillator
`timescale 1ns/100ps
`default_nettype none
module clock_source_model (
	// Core clock
	input wire logic clk_in,
	// Source pins
	output logic xtal_out,
	output logic tosc_out
);
	// ****************
	// Sources
	// ****************
	logic [2:0] phase = 3'h0;
	logic xtal = 1'b0;
	logic tosc = 1'b0;
	// Known levels before the first edge, one driver per pin
	assign xtal_out = xtal;
	assign tosc_out = tosc;
	// Fixed rates only, so no cycle-to-cycle frequency step
	always @(posedge clk_in) begin
		xtal <= ~xtal;
		phase <= phase + 3'h1;
		// Sixteen-cycle period keeps the core clock above four times it
		if (phase == 3'h7) begin
			tosc <= ~tosc;
		end
	end
endmodule
`default_nettype wire

// [testbench/system_clock_control_tb_top.sv]
// Self-checking testbench of the system clock control block
`timescale 1ns/100ps
`default_nettype none
module system_clock_control_tb_top;
	// ****************
	// Stimulus and observed signals
	// ****************
	localparam int DSHORT = 20;
	localparam int DLONG = 40;
	localparam logic [7:0] TRIM0 = 8'h5a; // Arbitrary factory value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] src = 4'h0;
	logic [1:0] startup_delay_fuse = 2'h0;
	logic clock_output_fuse = 1'b1;
	logic div8 = 1'b0;
	logic wake = 1'b0;
	logic port = 1'b0;
	logic [31:0] rdata;
	logic wreq, xtal, tosc, pin, cpu_en, io_en, adc_en, fl_en, range, ext_act, tosc_ok, tclk, tclk_ok;
	logic [7:0] trim;
	logic [3:0] div_sel;
	int error_cnt = 0;
	int tests_run = 0;

	// Core clock, 40 ns period
	always #20 clk = ~clk;

	// Block under test and its far side
	system_clock_control #(.DELAY_SHORT(DSHORT), .DELAY_LONG(DLONG), .FACTORY_TRIM(TRIM0)) dut_u (
		.CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
		.AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq),
		.CLOCK_SOURCE_SELECT_FUSE_IN(src), .STARTUP_DELAY_FUSE_IN(startup_delay_fuse), .CLOCK_OUTPUT_FUSE_IN(clock_output_fuse),
		.DIVIDE_BY_EIGHT_FUSE_IN(div8), .DEEP_WAKE_IN(wake), .CRYSTAL_INPUT_PIN_IN(xtal),
		.TIMER_OSC_INPUT_PIN_IN(tosc), .PORT_PIN_DATA_IN(port), .CLOCK_OUTPUT_PIN_OUT(pin),
		.CPU_CLK_EN_OUT(cpu_en), .IO_CLK_EN_OUT(io_en), .ADC_CLK_EN_OUT(adc_en), .FLASH_CLK_EN_OUT(fl_en),
		.RC_OSCILLATOR_TRIM_OUT(trim), .TRIM_RANGE_SELECT_OUT(range), .EXTERNAL_SOURCE_ACTIVE_OUT(ext_act),
		.TIMER_OSC_ALLOWED_OUT(tosc_ok), .TIMER_CLOCK_OUT(tclk), .TIMER_CLOCK_VALID_OUT(tclk_ok),
		.DIVIDER_SELECT_OUT(div_sel));
	clock_source_model src_u (.clk_in(clk), .xtal_out(xtal), .tosc_out(tosc));

	// ****************
	// Shared tasks
	// ****************
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One Avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= ~w;
		wdata <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 16);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 16) begin
			check(32'h1, 32'h0, "bus wait ran out");
			stop_test();
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] q;
		bus(1'b0, a, 8'h0, q);
		check(q, exp, msg);
	endtask

	task automatic div_chk(input logic [3:0] exp, input string msg);
		@(negedge clk);
		check({28'h0, div_sel}, {28'h0, exp}, msg);
	endtask

	// Unlock and divider write back to back, nothing may come between
	task automatic set_div(input logic [3:0] c);
		wr_reg(4'h4, 8'h80);
		wr_reg(4'h4, {4'h0, c});
		div_chk(c, "divider not taken");
	endtask

	task automatic do_reset(input logic [3:0] s, input logic [1:0] t, input logic d8);
		@(posedge clk);
		src <= s;
		startup_delay_fuse <= t;
		div8 <= d8;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
	endtask

	// Waits for an enable pulse; the cycle count since the call comes back
	task automatic next_pulse(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if ({io_en, adc_en, fl_en} !== {3{cpu_en}}) check(32'h0, 32'h1, "domains out of step");
		end while (cpu_en !== 1'b1 && n < 600);
		if (n >= 600) begin
			check(32'h1, 32'h0, "no enable pulse");
			stop_test();
		end
	endtask

	task automatic period(input int exp, input string msg);
		int n;
		next_pulse(n);
		next_pulse(n);
		next_pulse(n);
		check(n, exp, msg);
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		do_reset(clk_ctrl_pkg::SRC_EXTERNAL, 2'h0, 1'b1);
		rd_chk(4'h0, {24'h0, TRIM0}, "factory trim not loaded");
		rd_chk(4'h4, 32'h3, "divide-by-eight reset value");
		rd_chk(4'h1, 32'h0, "unmapped read not zero");
		repeat (2) begin
			@(negedge clk);
			check(ext_act, xtal, "external source not passed");
		end
		period(8, "reset divider rate");
		rd_chk(4'hc, 32'h4, "not running");
		$display("Test reset done");
	endtask

	task automatic t_start();
		int n;
		for (int t = 0; t < 4; t++) begin
			do_reset(clk_ctrl_pkg::SRC_EXTERNAL, t[1:0], 1'b0);
			next_pulse(n);
			n = n - (t == 0 ? 0 : (t == 1 ? DSHORT : DLONG));
			check(n >= 14 && n <= 18, 1'b1, "start-up delay off");
		end
		$display("Test start-up done");
	endtask

	// No memory write runs in this bench, so any trim value is safe
	task automatic t_trim();
		wr_reg(4'h0, 8'h7f);
		rd_chk(4'h0, 32'h7f, "trim readback");
		check({range, trim}, 9'h07f, "low range trim");
		wr_reg(4'h0, 8'h80);
		rd_chk(4'h0, 32'h80, "trim readback");
		check({range, trim}, 9'h180, "high range trim");
		$display("Test trim done");
	endtask

	// Codes 0 to 9, reserved code 9 acting as the largest factor
	task automatic t_div();
		int t;
		logic p;
		for (int c = 0; c < 10; c++) begin
			set_div(c[3:0]);
			rd_chk(4'h4, c, "divider readback");
			period(1 << (c > 8 ? 8 : c), "divided rate");
			if (c < 4) begin
				t = 0;
				p = pin;
				repeat (32) begin
					@(posedge clk);
					if (pin !== p) t++;
					p = pin;
				end
				check(t, 32 >> c, "clock output rate");
			end
		end
		$display("Test divider done");
	endtask

	task automatic t_lock();
		set_div(4'h2);
		wr_reg(4'h4, 8'h05);
		div_chk(4'h2, "locked write took effect");
		wr_reg(4'h4, 8'h81);
		wr_reg(4'h4, 8'h05);
		div_chk(4'h2, "enable with other bits set");
		wr_reg(4'h4, 8'h80);
		rd_chk(4'h4, 32'h82, "enable not shown");
		rd_chk(4'h4, 32'h02, "enable not cleared");
		wr_reg(4'h4, 8'h05);
		div_chk(4'h2, "write after window");
		wr_reg(4'h4, 8'h80);
		wr_reg(4'h4, 8'h80);
		@(posedge clk);
		wr_reg(4'h4, 8'h05);
		div_chk(4'h2, "window extended");
		$display("Test unlock done");
	endtask

	// Rate change: no short period, new rate on time
	task automatic t_switch(input logic [3:0] a, input logic [3:0] b);
		int n, g;
		set_div(a);
		period(1 << a, "old rate");
		wr_reg(4'h4, 8'h80);
		wr_reg(4'h4, {4'h0, b});
		next_pulse(n);
		next_pulse(g);
		check(g >= (1 << (a < b ? a : b)), 1'b1, "short period in switch");
		check(n + g <= (1 << a) + 2 * (1 << b) + 2, 1'b1, "new rate late");
		$display("Test switch done");
	endtask

	task automatic t_pin_wake();
		int n;
		clock_output_fuse <= 1'b0;
		port <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(pin, 1'b1, "pin not port data");
		@(posedge clk);
		clock_output_fuse <= 1'b1;
		set_div(4'h0);
		// Let the divider adopt the undivided rate before sleeping
		next_pulse(n);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		next_pulse(n);
		check(n >= 6 && n <= 8, 1'b1, "wake delay off");
		$display("Test pin and wake done");
	endtask

	task automatic t_timer();
		do_reset(clk_ctrl_pkg::SRC_RC_OSC, 2'h0, 1'b0);
		wr_reg(4'h8, 8'h40);
		rd_chk(4'h8, 32'h40, "timer clock select readback");
		repeat (20) begin
			@(negedge clk);
			check({ext_act, tosc_ok, tclk_ok, tclk}, {3'h3, tosc}, "timer clock path");
		end
		do_reset(clk_ctrl_pkg::SRC_EXTERNAL, 2'h0, 1'b0);
		wr_reg(4'h8, 8'h40);
		@(negedge clk);
		check({ext_act, tosc_ok, tclk_ok}, {xtal, 2'h0}, "timer allowed off RC");
		$display("Test timer done");
	endtask

	// Main sequence
	initial begin
		t_reset();
		t_trim();
		t_start();
		t_div();
		t_lock();
		t_switch(4'h3, 4'h1);
		t_switch(4'h1, 4'h3);
		t_pin_wake();
		t_timer();
		stop_test();
	end
endmodule
`default_nettype wire
